/* sfsp_flash_status.sv */
// status register, write enable latch and block protection of a serial flash
// Notes on behaviour
// - read status repeats the status byte while select stays low
// - page write needs one data byte; only the last 256 bytes are kept
// - opcode 06 sets the write enable latch, status bit 1
// - opcode 04 clears the write enable latch
// - latch clears at power-up and when any write or erase cycle completes
// - opcode 05 shifts out the status register
// - status bit 0 is high exactly while a write or erase cycle runs
// - with the latch clear every write or erase command is refused
// - bulk erase only runs when all protect bits are zero
// - page writes and sector erases into the protected region are refused
// - protect bits are kept in nonvolatile storage across power cycles
// - four-sector decoding: none, sector 3, sectors 2-3, all
// - eight-sector decoding: none, 7, 6-7, 4-7, top bit set protects all
// - 32-sector decoding: none, 31, 30-31, 28-31, 24-31, 16-31, all
// - 128-sector decoding: none, 126-127 doubling up to 64-127, then all
// - 64-sector decoding: none, 63, 62-63 doubling up to 32-63, then all
// - read status is answered at any time, also during a busy cycle
// - all bytes travel most significant bit first both ways
// - input bits are latched on serial clock rising edges after select falls
// - write-type commands end on a byte boundary or are discarded
// - while busy, memory access commands are refused and the cycle continues
`timescale 1ns/1ps
module sfsp_flash_status #(
    parameter int SECTORS = sfsp_pkg::DEF_SECTORS,
    parameter int WR_STATUS_CYC = sfsp_pkg::WR_STATUS_CYC,
    parameter int PAGE_WRITE_CYC = sfsp_pkg::PAGE_WRITE_CYC,
    parameter int SECTOR_ERASE_CYC = sfsp_pkg::SECTOR_ERASE_CYC,
    parameter int BULK_ERASE_CYC = sfsp_pkg::BULK_ERASE_CYC
) (
    // clock, reset, enable
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_clk_en,
    // serial link
    input wire logic i_serial_clock,
    input wire logic i_chip_select_n,
    input wire logic i_serial_data_in,
    output logic o_serial_data_out,
    output logic o_serial_data_oe,
    // nonvolatile protect storage
    input wire logic [2:0] i_nv_protect,
    output logic o_nv_protect_wr,
    output logic [2:0] o_nv_protect_data,
    // array engine side
    output sfsp_pkg::sfsp_mem_req_t o_mem_req,
    input wire logic [7:0] i_page_rd_idx,
    output logic [7:0] o_page_rd_data,
    // observation
    output logic [7:0] o_status
);
    localparam logic [2:0] BP_MASK = (SECTORS == 4) ? 3'h3 : 3'h7;

    generate
        if (SECTORS != 4 && SECTORS != 8 && SECTORS != 32 && SECTORS != 64
                && SECTORS != 128) begin : g_bad_sectors
            $error("unsupported sector count");
        end
        if (WR_STATUS_CYC < 1 || PAGE_WRITE_CYC < 1 || SECTOR_ERASE_CYC < 1
                || BULK_ERASE_CYC < 1) begin : g_bad_cycles
            $error("cycle counts must be at least one");
        end
    endgenerate

    typedef struct packed {
        sfsp_pkg::sfsp_state_t st;
        logic [2:0] bitc;
        logic [7:0] sh;
        logic [7:0] op;
        logic [1:0] abyte;
        logic [23:0] addr;
        logic [8:0] dcnt;
        logic [7:0] wptr;
        logic [7:0] sr_new;
        logic wel;
        logic busy;
        logic [31:0] timer;
        sfsp_pkg::sfsp_mem_op_t kind;
        logic [2:0] bp;
        logic nv_loaded;
        logic nv_wr;
        logic [7:0] osh;
        logic [2:0] ocnt;
        logic do_q;
        logic oe_q;
        logic [7:0] stat;
        sfsp_pkg::sfsp_mem_req_t req;
    } sfsp_main_st_t;

    logic rst_meta_q;
    logic rst_n;
    sfsp_main_st_t q;
    sfsp_main_st_t d;
    sfsp_pkg::sfsp_link_ev_t ev;
    logic hit;
    logic exec;
    logic [7:0] byte_w;
    logic [7:0] status_now;
    logic buf_we;
    logic [7:0] page_buf [sfsp_pkg::PAGE_BYTES];
    logic [7:0] rd_q;

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    sfsp_link_sync u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(rst_n),
        .i_clk_en(i_clk_en),
        .i_serial_clock(i_serial_clock),
        .i_chip_select_n(i_chip_select_n),
        .i_serial_data_in(i_serial_data_in),
        .o_ev(ev)
    );

    sfsp_protect_map #(.SECTORS(SECTORS)) u_map (
        .i_level(q.bp),
        .i_addr(q.addr),
        .o_hit(hit)
    );

    // unused upper bits read zero
    assign status_now = {3'h0, q.bp, q.wel, q.busy};
    assign byte_w = {q.sh[6:0], ev.din};
    // commands run only when select rises on a byte boundary
    assign exec = ev.cs_rise && (q.bitc == 3'h0) && (q.st == sfsp_pkg::ST_END
        || (q.st == sfsp_pkg::ST_DATA && q.dcnt != 9'h000));

    always_comb begin
        d = q;
        buf_we = 1'b0;
        d.nv_wr = 1'b0;
        d.req.start = 1'b0;
        d.stat = status_now;
        // protect level comes back from nonvolatile storage once after reset
        if (!q.nv_loaded) begin
            d.bp = i_nv_protect & BP_MASK;
            d.nv_loaded = 1'b1;
        end
        if (q.busy) begin
            if (q.timer == 32'h0) begin
                d.busy = 1'b0;
                d.wel = 1'b0;
                if (q.kind == sfsp_pkg::MEM_STATUS) begin
                    d.bp = q.sr_new[sfsp_pkg::STAT_BP_LSB +: sfsp_pkg::STAT_BP_W] & BP_MASK;
                    d.nv_wr = 1'b1;
                end
            end else begin
                d.timer = q.timer - 32'h1;
            end
        end
        if (ev.cs_n) begin
            d.st = sfsp_pkg::ST_OPCODE;
            d.bitc = 3'h0;
            d.oe_q = 1'b0;
            d.ocnt = 3'h0;
            if (exec) begin
                d.req.addr = q.addr;
                d.req.count = q.dcnt;
                d.req.base = (q.dcnt == 9'h100) ? q.wptr : 8'h00;
                case (q.op)
                    sfsp_pkg::OP_WR_ENABLE: d.wel = 1'b1;
                    sfsp_pkg::OP_WR_DISABLE: d.wel = 1'b0;
                    sfsp_pkg::OP_WR_STATUS: begin
                        if (q.wel) begin
                            d.busy = 1'b1;
                            d.kind = sfsp_pkg::MEM_STATUS;
                            d.timer = 32'(WR_STATUS_CYC - 1);
                        end
                    end
                    sfsp_pkg::OP_PAGE_WRITE: begin
                        if (q.wel && !hit) begin
                            d.busy = 1'b1;
                            d.kind = sfsp_pkg::MEM_PAGE;
                            d.timer = 32'(PAGE_WRITE_CYC - 1);
                        end
                    end
                    sfsp_pkg::OP_SECTOR_ERASE: begin
                        if (q.wel && !hit) begin
                            d.busy = 1'b1;
                            d.kind = sfsp_pkg::MEM_SECTOR;
                            d.timer = 32'(SECTOR_ERASE_CYC - 1);
                        end
                    end
                    sfsp_pkg::OP_BULK_ERASE: begin
                        if (q.wel && q.bp == 3'h0) begin
                            d.busy = 1'b1;
                            d.kind = sfsp_pkg::MEM_BULK;
                            d.timer = 32'(BULK_ERASE_CYC - 1);
                        end
                    end
                    default: d.busy = q.busy;
                endcase
                d.req.op = d.kind;
                // status writes stay inside this block
                d.req.start = d.busy && !q.busy && d.kind != sfsp_pkg::MEM_STATUS;
            end
        end else begin
            if (ev.fall && q.st == sfsp_pkg::ST_STATUS) begin
                d.oe_q = 1'b1;
                d.do_q = q.osh[7];
                d.ocnt = q.ocnt + 3'h1;
                // fresh copy each byte so a busy poll sees the flag drop
                d.osh = (q.ocnt == 3'h7) ? status_now : {q.osh[6:0], 1'b0};
            end
            if (ev.rise) begin
                d.bitc = q.bitc + 3'h1;
                d.sh = byte_w;
                // clocks past a complete command move it to ST_SKIP, which exec never runs
                if (q.st == sfsp_pkg::ST_END) begin
                    d.st = sfsp_pkg::ST_SKIP;
                end
                if (q.bitc == 3'h7) begin
                    case (q.st)
                        sfsp_pkg::ST_OPCODE: begin
                            d.op = byte_w;
                            d.abyte = 2'h0;
                            d.dcnt = 9'h000;
                            d.wptr = 8'h00;
                            case (byte_w)
                                sfsp_pkg::OP_RD_STATUS: begin
                                    d.st = sfsp_pkg::ST_STATUS;
                                    d.osh = status_now;
                                end
                                sfsp_pkg::OP_WR_ENABLE, sfsp_pkg::OP_WR_DISABLE,
                                sfsp_pkg::OP_BULK_ERASE: begin
                                    d.st = q.busy ? sfsp_pkg::ST_SKIP : sfsp_pkg::ST_END;
                                end
                                sfsp_pkg::OP_WR_STATUS: begin
                                    d.st = q.busy ? sfsp_pkg::ST_SKIP : sfsp_pkg::ST_WDATA;
                                end
                                sfsp_pkg::OP_PAGE_WRITE, sfsp_pkg::OP_SECTOR_ERASE: begin
                                    d.st = q.busy ? sfsp_pkg::ST_SKIP : sfsp_pkg::ST_ADDR;
                                end
                                default: d.st = sfsp_pkg::ST_SKIP;
                            endcase
                        end
                        sfsp_pkg::ST_ADDR: begin
                            d.addr = {q.addr[15:0], byte_w};
                            d.abyte = q.abyte + 2'h1;
                            if (q.abyte == 2'(sfsp_pkg::ADDR_BYTES - 1)) begin
                                d.st = (q.op == sfsp_pkg::OP_PAGE_WRITE) ?
                                    sfsp_pkg::ST_DATA : sfsp_pkg::ST_END;
                            end
                        end
                        sfsp_pkg::ST_WDATA: begin
                            d.sr_new = byte_w;
                            d.st = sfsp_pkg::ST_END;
                        end
                        sfsp_pkg::ST_DATA: begin
                            // ring buffer: older bytes are overwritten
                            buf_we = 1'b1;
                            d.wptr = q.wptr + 8'h01;
                            if (q.dcnt != 9'h100) begin
                                d.dcnt = q.dcnt + 9'h001;
                            end
                        end
                        default: d.st = d.st;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.st <= sfsp_pkg::ST_OPCODE;
            q.bp <= sfsp_pkg::BP_RESET;
        end else if (i_clk_en) begin
            q <= d;
        end
    end

    // page data storage, read by the array engine during a page cycle
    always_ff @(posedge i_sys_clk) begin
        if (i_clk_en) begin
            if (buf_we) begin
                page_buf[q.wptr] <= byte_w;
            end
            rd_q <= page_buf[i_page_rd_idx];
        end
    end

    assign o_serial_data_out = q.do_q;
    assign o_serial_data_oe = q.oe_q;
    assign o_nv_protect_wr = q.nv_wr;
    assign o_nv_protect_data = q.bp;
    assign o_mem_req = q.req;
    assign o_page_rd_data = rd_q;
    assign o_status = q.stat;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!rst_n);

    wren_sets_a: assert property (i_clk_en && exec && q.op == sfsp_pkg::OP_WR_ENABLE
        |=> q.wel) else $error("write enable did not set latch");
    wrdi_clears_a: assert property (i_clk_en && exec && q.op == sfsp_pkg::OP_WR_DISABLE
        |=> !q.wel) else $error("write disable did not clear latch");
    cycle_end_wel_a: assert property ($fell(q.busy) |-> !q.wel)
        else $error("latch still set after cycle end");
    busy_holds_a: assert property (i_clk_en && !q.busy && d.busy |=> q.busy [*2])
        else $error("busy flag dropped early");
    no_wel_refuse_a: assert property (i_clk_en && exec && !q.wel
        && q.op != sfsp_pkg::OP_WR_ENABLE |=> !q.busy && !o_mem_req.start)
        else $error("write accepted without latch");
    bulk_protect_a: assert property (i_clk_en && exec && q.op == sfsp_pkg::OP_BULK_ERASE
        && q.bp != 3'h0 |=> !q.busy) else $error("bulk erase ran while protected");
    sector_protect_a: assert property (i_clk_en && exec && hit
        && q.op == sfsp_pkg::OP_SECTOR_ERASE |=> !o_mem_req.start)
        else $error("protected sector erased");
    busy_refuse_a: assert property (i_clk_en && q.busy && ev.rise && !ev.cs_n
        && q.st == sfsp_pkg::ST_OPCODE && q.bitc == 3'h7
        && byte_w == sfsp_pkg::OP_PAGE_WRITE |=> q.st == sfsp_pkg::ST_SKIP)
        else $error("command taken while busy");
    // a cycle that completes in the same clock clears the latch on its own
    boundary_a: assert property (i_clk_en && ev.cs_rise && q.bitc != 3'h0
        && !(q.busy && q.timer == 32'h0)
        |=> $stable(q.wel) && !o_mem_req.start) else $error("partial byte executed");
    status_drive_a: assert property (i_clk_en && ev.fall && !ev.cs_n
        && q.st == sfsp_pkg::ST_STATUS |=> o_serial_data_oe && o_serial_data_out == $past(q.osh[7]))
        else $error("status bit not driven");

    wren_seen_c: cover property (exec && q.op == sfsp_pkg::OP_WR_ENABLE);
    page_start_c: cover property (o_mem_req.start && o_mem_req.op == sfsp_pkg::MEM_PAGE);
    poll_busy_c: cover property (q.busy && q.st == sfsp_pkg::ST_STATUS && q.ocnt == 3'h7);
    status_wr_c: cover property (o_nv_protect_wr);
endmodule

/* sfsp_pkg.sv */
// shared constants and types for the serial flash status and protection block
package sfsp_pkg;
    // command opcodes, shifted most significant bit first
    localparam logic [7:0] OP_WR_ENABLE = 8'h06;
    localparam logic [7:0] OP_WR_DISABLE = 8'h04;
    localparam logic [7:0] OP_RD_STATUS = 8'h05;
    localparam logic [7:0] OP_WR_STATUS = 8'h01;
    localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
    localparam logic [7:0] OP_BULK_ERASE = 8'hc7;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'hd8;

    // status byte layout
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_WEL_BIT = 1;
    localparam int STAT_BP_LSB = 2;
    localparam int STAT_BP_W = 3;
    localparam logic [2:0] BP_RESET = 3'h0;

    // framing
    localparam int ADDR_BYTES = 3;
    localparam int PAGE_BYTES = 256;
    localparam int DEF_SECTORS = 32;

    // self-timed cycle lengths, in microseconds, and their clock counts
    localparam int CLK_PERIOD_NS = 100;
    localparam int WR_STATUS_US = 5000;
    localparam int PAGE_WRITE_US = 5000;
    localparam int SECTOR_ERASE_US = 5000;
    localparam int BULK_ERASE_US = 5000;
    localparam int WR_STATUS_CYC = WR_STATUS_US * 1000 / CLK_PERIOD_NS;
    localparam int PAGE_WRITE_CYC = PAGE_WRITE_US * 1000 / CLK_PERIOD_NS;
    localparam int SECTOR_ERASE_CYC = SECTOR_ERASE_US * 1000 / CLK_PERIOD_NS;
    localparam int BULK_ERASE_CYC = BULK_ERASE_US * 1000 / CLK_PERIOD_NS;

    typedef enum logic [1:0] {MEM_PAGE, MEM_SECTOR, MEM_BULK, MEM_STATUS} sfsp_mem_op_t;

    typedef enum logic [2:0] {
        ST_OPCODE, ST_ADDR, ST_WDATA, ST_DATA, ST_END, ST_STATUS, ST_SKIP
    } sfsp_state_t;

    // request handed to the array engine when a page write or erase cycle starts
    typedef struct packed {
        logic start;
        sfsp_mem_op_t op;
        logic [23:0] addr;
        logic [8:0] count;
        logic [7:0] base;
    } sfsp_mem_req_t;

    // link events seen in the system clock domain
    typedef struct packed {
        logic rise;
        logic fall;
        logic cs_n;
        logic cs_rise;
        logic din;
    } sfsp_link_ev_t;
endpackage

/* sfsp_link_sync.sv */
// synchronises the serial link pins and finds clock edges and the select rising edge
`timescale 1ns/1ps
module sfsp_link_sync (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    // raw link pins
    input wire logic i_serial_clock,
    input wire logic i_chip_select_n,
    input wire logic i_serial_data_in,
    // events
    output sfsp_pkg::sfsp_link_ev_t o_ev
);
    typedef struct packed {
        logic [2:0] meta;
        logic [2:0] sync;
        logic sck_prev;
        logic csn_prev;
    } sfsp_sync_st_t;

    sfsp_sync_st_t q;
    sfsp_sync_st_t d;

    always_comb begin
        d = q;
        d.meta = {i_serial_clock, i_chip_select_n, i_serial_data_in};
        d.sync = q.meta;
        d.sck_prev = q.sync[2];
        d.csn_prev = q.sync[1];
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '{meta: 3'h2, sync: 3'h2, sck_prev: 1'b0, csn_prev: 1'b1};
        end else if (i_clk_en) begin
            q <= d;
        end
    end

    // only the second stage and its delayed copy are looked at
    always_comb begin
        o_ev.rise = q.sync[2] & ~q.sck_prev;
        o_ev.fall = ~q.sync[2] & q.sck_prev;
        o_ev.cs_n = q.sync[1];
        o_ev.cs_rise = q.sync[1] & ~q.csn_prev;
        o_ev.din = q.sync[0];
    end
endmodule

/* sfsp_protect_map.sv */
// decodes the protect level into the protected top region of the array
`timescale 1ns/1ps
module sfsp_protect_map #(
    parameter int SECTORS = 32
) (
    // protect level and target
    input wire logic [2:0] i_level,
    input wire logic [23:0] i_addr,
    // result
    output logic o_hit
);
    localparam int SHIFT = (SECTORS == 4) ? 15 : ((SECTORS == 64) ? 18 : 16);

    int lvl;
    int n;
    int sec;

    always_comb begin
        lvl = int'(i_level);
        sec = int'(i_addr[23:SHIFT]) & (SECTORS - 1);
        n = 0;
        case (SECTORS)
            4: n = (lvl == 3) ? 4 : lvl;
            8: n = (lvl >= 4) ? 8 : ((lvl == 3) ? 4 : lvl);
            32: n = (lvl >= 6) ? 32 : ((lvl == 0) ? 0 : (1 << (lvl - 1)));
            64: n = (lvl == 0) ? 0 : (1 << (lvl - 1));
            default: n = (lvl == 0) ? 0 : (1 << lvl);
        endcase
        // protected region is always the top n sectors
        o_hit = (n != 0) && (sec >= SECTORS - n);
    end
endmodule

/* sfsp_host_model.sv */
// host controller model that drives the serial link of the flash block
`timescale 1ns/1ps
module sfsp_host_model (
    // clock
    input wire logic i_sys_clk,
    // serial link
    output logic o_serial_clock,
    output logic o_chip_select_n,
    output logic o_serial_data_in,
    input wire logic i_serial_data_out
);
    initial begin
        o_serial_clock = 1'b0;
        o_chip_select_n = 1'b1;
        o_serial_data_in = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask
    task automatic sel();
        tick(1);
        o_chip_select_n <= 1'b0;
        tick(4);
    endtask
    // callers end write-type frames on whole bytes unless a scenario means otherwise
    task automatic desel();
        tick(4);
        o_chip_select_n <= 1'b1;
        // released line flips so a stale bit is never mistaken for data
        o_serial_data_in <= ~o_serial_data_in;
        tick(8);
    endtask
    // four system cycles per half period give the 800 ns link clock
    task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            o_serial_data_in <= tx[i];
            tick(4);
            o_serial_clock <= 1'b1;
            // sample mid-way through the high phase, the device updates after falling edges
            tick(2);
            rx[i] = i_serial_data_out;
            tick(2);
            o_serial_clock <= 1'b0;
        end
    endtask
endmodule

/* sfsp_flash_status_tb.sv */
// self-checking testbench for the flash status and protection block
`timescale 1ns/1ps
module sfsp_flash_status_tb;
    localparam int CYC = 600;
    localparam int SZ [5] = '{4, 8, 32, 64, 128};
    localparam int SH [5] = '{15, 16, 16, 18, 16};
    logic clk, rst_n, sck, cs_n, sdi, sdo, oe, nv_wr;
    logic [2:0] nv_data, lvl;
    sfsp_pkg::sfsp_mem_req_t greq [5];
    logic [7:0] idx, rd_data, status, s, s2;
    sfsp_pkg::sfsp_mem_req_t req, last_req;
    int err_total, n_compared, starts, nv_writes, n, dn;
    int gs [5];

    sfsp_flash_status #(.SECTORS(32), .WR_STATUS_CYC(CYC), .PAGE_WRITE_CYC(CYC),
        .SECTOR_ERASE_CYC(CYC), .BULK_ERASE_CYC(CYC)) DUT (
        .i_sys_clk(clk), .i_resetn(rst_n), .i_clk_en(1'b1),
        .i_serial_clock(sck), .i_chip_select_n(cs_n), .i_serial_data_in(sdi),
        .o_serial_data_out(sdo), .o_serial_data_oe(oe),
        .i_nv_protect(lvl), .o_nv_protect_wr(nv_wr), .o_nv_protect_data(nv_data),
        .o_mem_req(req), .i_page_rd_idx(idx), .o_page_rd_data(rd_data), .o_status(status));
    sfsp_host_model H (.i_sys_clk(clk), .o_serial_clock(sck), .o_chip_select_n(cs_n),
        .o_serial_data_in(sdi), .i_serial_data_out(sdo));
    // one short-cycle instance per array size, listening on the same link
    for (genvar g = 0; g < 5; g++) begin : g_size
        sfsp_flash_status #(.SECTORS(SZ[g]), .WR_STATUS_CYC(4), .PAGE_WRITE_CYC(4),
            .SECTOR_ERASE_CYC(4), .BULK_ERASE_CYC(4)) DUT (
            .i_sys_clk(clk), .i_resetn(rst_n), .i_clk_en(1'b1),
            .i_serial_clock(sck), .i_chip_select_n(cs_n), .i_serial_data_in(sdi),
            .o_serial_data_out(), .o_serial_data_oe(), .i_nv_protect(lvl),
            .o_nv_protect_wr(), .o_nv_protect_data(), .o_mem_req(greq[g]),
            .i_page_rd_idx(idx), .o_page_rd_data(), .o_status());
    end

    always @(posedge clk) begin
        if (req.start === 1'b1) begin
            starts++;
            last_req <= req;
        end
        if (nv_wr === 1'b1) begin
            nv_writes++;
        end
        for (int g = 0; g < 5; g++) begin
            if (greq[g].start === 1'b1) begin
                gs[g]++;
            end
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (exp !== got) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic xfer(input logic [7:0] b);
        logic [7:0] r;
        H.shift(b, 8, r);
    endtask
    task automatic rd_st();
        H.sel();
        xfer(sfsp_pkg::OP_RD_STATUS);
        H.shift(8'h00, 8, s);
        H.desel();
    endtask
    task automatic st(input logic [7:0] e);
        rd_st();
        chk("status", e, s);
    endtask
    task automatic op1(input logic [7:0] b);
        H.sel();
        xfer(b);
        H.desel();
    endtask
    // leaves select low so the caller can add data bytes
    task automatic op_addr(input logic [7:0] b, input logic [23:0] a);
        H.sel();
        xfer(b);
        xfer(a[23:16]);
        xfer(a[15:8]);
        xfer(a[7:0]);
    endtask
    task automatic wr_status(input logic [7:0] v);
        op1(sfsp_pkg::OP_WR_ENABLE);
        H.sel();
        xfer(sfsp_pkg::OP_WR_STATUS);
        xfer(v);
        H.desel();
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 60; i++) begin
            rd_st();
            if (s[0] === 1'b0) break;
        end
        chk("idle", 1'b0, s[0]);
    endtask
    // write enable, then a sector erase at a; dn counts starts of size instance g
    task automatic erase_at(input int g, input logic [23:0] a, output int dn);
        int c;
        c = gs[g];
        op1(sfsp_pkg::OP_WR_ENABLE);
        op_addr(sfsp_pkg::OP_SECTOR_ERASE, a);
        H.desel();
        dn = gs[g] - c;
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (90000) @(posedge clk);
        err_total++;
        $display("BAD watchdog expected finish seen timeout");
        report_and_stop();
    end
    initial begin
        rst_n = 1'b0;
        idx = 8'h00;
        lvl = 3'h0;
        err_total = 0;
        n_compared = 0;
        starts = 0;
        nv_writes = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge clk);
        st(8'h00);
        H.sel();
        H.shift(sfsp_pkg::OP_WR_ENABLE, 7, s);
        H.desel();
        st(8'h00);
        op1(sfsp_pkg::OP_WR_ENABLE);
        H.sel();
        xfer(sfsp_pkg::OP_RD_STATUS);
        H.shift(8'h00, 8, s);
        H.shift(8'h00, 8, s2);
        H.desel();
        chk("status first", 8'h02, s);
        chk("status repeat", 8'h02, s2);
        chk("oe idle", 1'b0, oe);
        op1(sfsp_pkg::OP_WR_DISABLE);
        st(8'h00);
        op_addr(sfsp_pkg::OP_PAGE_WRITE, 24'h000010);
        xfer(8'h55);
        H.desel();
        st(8'h00);
        chk("starts", 0, starts);
        wr_status(8'h14);
        st(8'h03);
        wait_idle();
        st(8'h14);
        chk("status port", 8'h14, status);
        chk("nv data", 3'h5, nv_data);
        chk("nv writes", 1, nv_writes);
        op1(sfsp_pkg::OP_WR_ENABLE);
        op1(sfsp_pkg::OP_BULK_ERASE);
        st(8'h16);
        op_addr(sfsp_pkg::OP_SECTOR_ERASE, 24'h100000);
        H.desel();
        st(8'h16);
        chk("starts", 0, starts);
        op_addr(sfsp_pkg::OP_SECTOR_ERASE, 24'h0f0000);
        H.desel();
        st(8'h17);
        wait_idle();
        st(8'h14);
        chk("starts", 1, starts);
        chk("erase op", sfsp_pkg::MEM_SECTOR, last_req.op);
        chk("erase addr", 24'h0f0000, last_req.addr);
        wr_status(8'h00);
        wait_idle();
        op1(sfsp_pkg::OP_WR_ENABLE);
        op_addr(sfsp_pkg::OP_PAGE_WRITE, 24'h000100);
        for (int k = 0; k < 258; k++) begin
            xfer(k < 256 ? k[7:0] : 8'hee);
        end
        H.desel();
        // a second command while the program cycle runs must be ignored
        op_addr(sfsp_pkg::OP_SECTOR_ERASE, 24'h000000);
        H.desel();
        wait_idle();
        st(8'h00);
        chk("starts", 2, starts);
        chk("page op", sfsp_pkg::MEM_PAGE, last_req.op);
        chk("page count", 9'h100, last_req.count);
        chk("page base", 8'h02, last_req.base);
        idx <= 8'h00;
        repeat (2) @(posedge clk);
        chk("ring 0", 8'hee, rd_data);
        idx <= 8'h02;
        repeat (2) @(posedge clk);
        chk("ring 2", 8'h02, rd_data);
        op1(sfsp_pkg::OP_WR_ENABLE);
        op1(sfsp_pkg::OP_BULK_ERASE);
        wait_idle();
        chk("bulk op", sfsp_pkg::MEM_BULK, last_req.op);
        // every size loads the level at reset, then erases either side of the boundary; levels above 3 skip the four-sector size
        for (int l = 0; l < 8; l++) begin
            lvl <= 3'(l);
            rst_n <= 1'b0;
            repeat (3) @(posedge clk);
            rst_n <= 1'b1;
            repeat (10) @(posedge clk);
            chk("nv load", l, nv_data);
            for (int g = 0; g < 5; g++) begin
                if (SZ[g] == 4 && l > 3) continue;
                n = (l == 0) ? 0 : ((SZ[g] == 128 ? 2 : 1) << (l - 1));
                n = (n > SZ[g]) ? SZ[g] : n;
                if (n > 0) begin
                    erase_at(g, 24'((SZ[g] - n) << SH[g]), dn);
                    chk("map hit", 0, dn);
                end
                if (n < SZ[g]) begin
                    erase_at(g, 24'(((SZ[g] - n) << SH[g]) - 1), dn);
                    chk("map miss", 1, dn);
                end
            end
        end
        report_and_stop();
    end
endmodule
